// ### shared/mpm_pkg.sv
package mpm_pkg;

  // register-bus addresses of the control and latch registers
  localparam logic [7:0] ADDR_CLAMP_PARA = 8'h84;
  localparam logic [7:0] ADDR_SYNC_PIN   = 8'h85;
  localparam logic [7:0] ADDR_OUT_PORT   = 8'hBB;
  localparam logic [7:0] ADDR_SPECIAL    = 8'hC8;

  // port widths
  localparam int P1_W = 6;
  localparam int P2_W = 8;
  localparam int P3_W = 8;
  localparam int P4_W = 7;

  // sync_and_pin_control field positions
  localparam int SPC_VSEP_EN     = 0;
  localparam int SPC_HOUT_POL    = 1;
  localparam int SPC_VOUT_POL    = 2;
  localparam int SPC_IRQ_SENSE   = 4;
  localparam int SPC_MOIRE0_EN   = 5;
  localparam int SPC_MOIRE1_EN   = 6;
  localparam int SPC_CLAMP_SUPP  = 7;

  // special_function_select field positions
  localparam int SFS_PIN24_EN    = 0;
  localparam int SFS_PIN27_EN    = 3;
  localparam int SFS_CLAMP_EN    = 4;
  localparam int SFS_SAFE_EN     = 5;
  localparam int SFS_TEST_EN     = 6;
  localparam int SFS_TEST_INV    = 7;

  // clamp_and_parabola_control field positions
  localparam int CPC_CLAMP_SRC   = 5;
  localparam int CPC_DUMMY_MASK  = 6;

  // pin positions of alternate functions
  localparam int P1_CLAMP_PIN    = 4;
  localparam int P1_SAFE_PIN     = 5;
  localparam int P2_TEST_PIN     = 3;
  localparam int P2_PWM_BASE     = 4;
  localparam int P3_SER_DATA_PIN = 0;
  localparam int P3_SER_CLK_PIN  = 1;
  localparam int PWM_PIN_CNT     = 4;

  // reset values
  localparam logic [7:0]      CTRL_RST  = 8'h00;
  localparam logic [P1_W-1:0] P1_RST    = 6'h3F;
  localparam logic [P2_W-1:0] P2_RST    = 8'hFF;
  localparam logic [P3_W-1:0] P3_RST    = 8'hFF;
  localparam logic [P4_W-1:0] P4_RST    = 7'h00;
  localparam logic [7:0]      RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    MPM_SER_SYNC   = 2'b00,
    MPM_SER_UART8  = 2'b01,
    MPM_SER_UART9F = 2'b10,
    MPM_SER_UART9V = 2'b11
  } mpm_ser_mode_t;

  typedef struct packed {
    logic clamp_suppress_in_vsync;
    logic moire_cancel_ch1_en;
    logic moire_cancel_ch0_en;
    logic ext_irq_sense_sel;
    logic vout_polarity_sel;
    logic hout_polarity_sel;
    logic vsync_separator_en;
  } mpm_sync_ctrl_t;

  typedef struct packed {
    logic test_pattern_invert;
    logic test_pattern_pin_alt_en;
    logic safe_area_pin_alt_en;
    logic clamp_pin_alt_en;
    logic [PWM_PIN_CNT-1:0] pwm_pin_alt_en;
  } mpm_special_t;

  typedef struct packed {
    logic dummy_vertical_event_irq_mask;
    logic clamp_source_sel;
  } mpm_clamp_ctrl_t;

endpackage : mpm_pkg

// ### design/mpm_pin_cell.sv
module mpm_pin_cell #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_latch,
  input  wire logic [W-1:0] i_alt_sel,
  input  wire logic [W-1:0] i_alt_val,
  input  wire logic [W-1:0] i_pin_in,
  output logic      [W-1:0] o_pin_out,
  output logic      [W-1:0] o_pin_oe,
  output logic      [W-1:0] o_pin_sync
);
  import mpm_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // pins are asynchronous to the core; meta_q feeds only sync_q
  // idle pins rest high on the pull-up, so clearing to 0 would fake a start bit
  // on rxd and a rising edge on the interrupt input just after reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_pin_in;
      sync_q <= meta_q;
    end
  end

  assign o_pin_sync = sync_q;

  // general pins are quasi-bidirectional: strong low, released high onto the pull-up
  // so the same pin can be read back; alternate functions drive push-pull
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pin_out <= '1;
      o_pin_oe  <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (i_alt_sel[i]) begin
          o_pin_out[i] <= i_alt_val[i];
          o_pin_oe[i]  <= 1'b1;
        end else begin
          o_pin_out[i] <= i_latch[i];
          o_pin_oe[i]  <= ~i_latch[i];
        end
      end
    end
  end

endmodule : mpm_pin_cell

// ### design/mpm_top.sv
// Notes on behaviour
// - control bit 0 enables vertical sync separator
// - bits 1,2 select hout/vout polarity, 1 negative
// - bit 4 selects external interrupt trigger sense
// - bits 5,6 enable moire cancel channel 0/1
// - bit 7 suppresses clamp pulses during vsync
// - port2 pins 4-7 carry pwm when enabled, latch 0
// - port2 pin 3 carries test pattern when enabled, latch 0
// - special bit 7 inverts the test pattern
// - port1 pin 4 carries clamp when enabled, latch 0
// - port1 pin 5 carries safe-area when enabled, latch 0
// - mask bit 6 blocks dummy vertical event interrupt
// - clamp bit 5 selects clamp pulse source
// - port latch 1 releases pin high onto the pull-up, 0 drives low
// - port read returns external pin level
// - port3 pin 0 is serial data or rxd
// - port3 pin 1 is serial clock or txd
// - output_port_latch is seven-bit output-only latch
module mpm_top #(
  parameter logic [7:0] ADDR_P1 = 8'h90,
  parameter logic [7:0] ADDR_P2 = 8'hA0,
  parameter logic [7:0] ADDR_P3 = 8'hB0
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  // register bus
  input  wire logic [7:0]                  i_sfr_addr,
  input  wire logic                        i_sfr_wr,
  input  wire logic                        i_sfr_rd,
  input  wire logic [7:0]                  i_sfr_wdata,
  output logic      [7:0]                  o_sfr_rdata,
  // control fields toward the sync processor and pwm blocks
  output mpm_pkg::mpm_sync_ctrl_t          o_sync_ctrl,
  output mpm_pkg::mpm_clamp_ctrl_t         o_clamp_ctrl,
  // internal function signals, same clock
  input  wire logic                        i_hclamp_pulse,
  input  wire logic                        i_vsync_active,
  input  wire logic                        i_safe_area_out,
  input  wire logic                        i_self_test_pattern,
  input  wire logic [mpm_pkg::PWM_PIN_CNT-1:0] i_static_pwm,
  input  wire logic                        i_vertical_event_irq_real,
  input  wire logic                        i_vertical_event_irq_dummy,
  output logic                             o_vertical_event_irq,
  // serial engine
  input  wire mpm_pkg::mpm_ser_mode_t      i_ser_mode,
  input  wire logic                        i_ser_sync_data_out,
  input  wire logic                        i_ser_sync_clk_out,
  input  wire logic                        i_ser_txd,
  output logic                             o_ser_sync_data_in,
  output logic                             o_ser_rxd,
  output logic                             o_external_irq_input,
  // pins
  input  wire logic [mpm_pkg::P1_W-1:0]    i_p1_pin,
  output logic      [mpm_pkg::P1_W-1:0]    o_p1_pin,
  output logic      [mpm_pkg::P1_W-1:0]    o_p1_pin_oe,
  input  wire logic [mpm_pkg::P2_W-1:0]    i_p2_pin,
  output logic      [mpm_pkg::P2_W-1:0]    o_p2_pin,
  output logic      [mpm_pkg::P2_W-1:0]    o_p2_pin_oe,
  input  wire logic [mpm_pkg::P3_W-1:0]    i_p3_pin,
  output logic      [mpm_pkg::P3_W-1:0]    o_p3_pin,
  output logic      [mpm_pkg::P3_W-1:0]    o_p3_pin_oe,
  output logic      [mpm_pkg::P3_W-1:0]    o_p3_pin_level,
  output logic      [mpm_pkg::P4_W-1:0]    o_output_port_latch
);
  import mpm_pkg::*;

  mpm_sync_ctrl_t  sync_ctrl_q;
  mpm_special_t    special_q;
  mpm_clamp_ctrl_t clamp_ctrl_q;
  logic [P1_W-1:0] p1_latch_q;
  logic [P2_W-1:0] p2_latch_q;
  logic [P3_W-1:0] p3_latch_q;
  logic [P4_W-1:0] p4_latch_q;
  logic [7:0]      rdata_q;
  logic            vertical_event_irq_q;

  logic [P1_W-1:0] p1_sync;
  logic [P2_W-1:0] p2_sync;
  logic [P3_W-1:0] p3_sync;
  logic [P1_W-1:0] p1_alt_sel;
  logic [P1_W-1:0] p1_alt_val;
  logic [P2_W-1:0] p2_alt_sel;
  logic [P2_W-1:0] p2_alt_val;
  logic [P3_W-1:0] p3_drive;
  logic            clamp_gated;
  logic            test_pattern_out;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] reg_addr,
                                  input logic wr);
    return wr && (addr == reg_addr);
  endfunction : wr_hit

  // an alternate output owns the pin only while enabled and its latch is cleared
  function automatic logic alt_owns(input logic en, input logic latch);
    return en && !latch;
  endfunction : alt_owns

  // sync_and_pin_control: write-only, reserved bit 3 is not stored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync_ctrl_q <= mpm_sync_ctrl_t'(CTRL_RST[6:0]);
    end else if (wr_hit(i_sfr_addr, ADDR_SYNC_PIN, i_sfr_wr)) begin
      sync_ctrl_q.vsync_separator_en      <= i_sfr_wdata[SPC_VSEP_EN];
      sync_ctrl_q.hout_polarity_sel       <= i_sfr_wdata[SPC_HOUT_POL];
      sync_ctrl_q.vout_polarity_sel       <= i_sfr_wdata[SPC_VOUT_POL];
      sync_ctrl_q.ext_irq_sense_sel       <= i_sfr_wdata[SPC_IRQ_SENSE];
      sync_ctrl_q.moire_cancel_ch0_en     <= i_sfr_wdata[SPC_MOIRE0_EN];
      sync_ctrl_q.moire_cancel_ch1_en     <= i_sfr_wdata[SPC_MOIRE1_EN];
      sync_ctrl_q.clamp_suppress_in_vsync <= i_sfr_wdata[SPC_CLAMP_SUPP];
    end
  end

  // special_function_select: all eight bits used
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      special_q <= mpm_special_t'(CTRL_RST);
    end else if (wr_hit(i_sfr_addr, ADDR_SPECIAL, i_sfr_wr)) begin
      special_q.pwm_pin_alt_en          <= i_sfr_wdata[SFS_PIN27_EN:SFS_PIN24_EN];
      special_q.clamp_pin_alt_en        <= i_sfr_wdata[SFS_CLAMP_EN];
      special_q.safe_area_pin_alt_en    <= i_sfr_wdata[SFS_SAFE_EN];
      special_q.test_pattern_pin_alt_en <= i_sfr_wdata[SFS_TEST_EN];
      special_q.test_pattern_invert     <= i_sfr_wdata[SFS_TEST_INV];
    end
  end

  // clamp_and_parabola_control: only bits 5 and 6 exist
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      clamp_ctrl_q <= mpm_clamp_ctrl_t'(CTRL_RST[1:0]);
    end else if (wr_hit(i_sfr_addr, ADDR_CLAMP_PARA, i_sfr_wr)) begin
      clamp_ctrl_q.clamp_source_sel  <= i_sfr_wdata[CPC_CLAMP_SRC];
      clamp_ctrl_q.dummy_vertical_event_irq_mask <= i_sfr_wdata[CPC_DUMMY_MASK];
    end
  end

  // port latches; general pins start released high so they can be read
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      p1_latch_q <= P1_RST;
    end else if (wr_hit(i_sfr_addr, ADDR_P1, i_sfr_wr)) begin
      p1_latch_q <= i_sfr_wdata[P1_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      p2_latch_q <= P2_RST;
    end else if (wr_hit(i_sfr_addr, ADDR_P2, i_sfr_wr)) begin
      p2_latch_q <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      p3_latch_q <= P3_RST;
    end else if (wr_hit(i_sfr_addr, ADDR_P3, i_sfr_wr)) begin
      p3_latch_q <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      p4_latch_q <= P4_RST;
    end else if (wr_hit(i_sfr_addr, ADDR_OUT_PORT, i_sfr_wr)) begin
      p4_latch_q <= i_sfr_wdata[P4_W-1:0];
    end
  end

  // read data: ports return pin levels, write-only registers and holes read zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= RDATA_RST;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_SPECIAL:    rdata_q <= special_q;
        ADDR_CLAMP_PARA: rdata_q <= {1'b0, clamp_ctrl_q, 5'h00};
        ADDR_P1:         rdata_q <= {2'b00, p1_sync};
        ADDR_P2:         rdata_q <= p2_sync;
        ADDR_P3:         rdata_q <= p3_sync;
        default:         rdata_q <= RDATA_RST;
      endcase
    end
  end

  assign o_sfr_rdata = rdata_q;

  // clamp pulse gated off across the vsync period when asked
  assign clamp_gated      = i_hclamp_pulse &
                            ~(sync_ctrl_q.clamp_suppress_in_vsync & i_vsync_active);
  assign test_pattern_out = i_self_test_pattern ^ special_q.test_pattern_invert;

  always_comb begin
    p1_alt_sel = '0;
    p1_alt_val = '1;
    p1_alt_sel[P1_CLAMP_PIN] = alt_owns(special_q.clamp_pin_alt_en,
                                        p1_latch_q[P1_CLAMP_PIN]);
    p1_alt_val[P1_CLAMP_PIN] = clamp_gated;
    p1_alt_sel[P1_SAFE_PIN]  = alt_owns(special_q.safe_area_pin_alt_en,
                                        p1_latch_q[P1_SAFE_PIN]);
    p1_alt_val[P1_SAFE_PIN]  = i_safe_area_out;
  end

  always_comb begin
    p2_alt_sel = '0;
    p2_alt_val = '1;
    p2_alt_sel[P2_TEST_PIN] = alt_owns(special_q.test_pattern_pin_alt_en,
                                       p2_latch_q[P2_TEST_PIN]);
    p2_alt_val[P2_TEST_PIN] = test_pattern_out;
    for (int i = 0; i < PWM_PIN_CNT; i++) begin
      p2_alt_sel[P2_PWM_BASE+i] = alt_owns(special_q.pwm_pin_alt_en[i],
                                           p2_latch_q[P2_PWM_BASE+i]);
      p2_alt_val[P2_PWM_BASE+i] = i_static_pwm[i];
    end
  end

  // port 3 has no enables: the serial output is ANDed with the latch,
  // which therefore must be left high for the alternate function
  always_comb begin
    p3_drive = p3_latch_q;
    if (i_ser_mode == MPM_SER_SYNC) begin
      p3_drive[P3_SER_DATA_PIN] = p3_latch_q[P3_SER_DATA_PIN] & i_ser_sync_data_out;
      p3_drive[P3_SER_CLK_PIN]  = p3_latch_q[P3_SER_CLK_PIN] & i_ser_sync_clk_out;
    end else begin
      p3_drive[P3_SER_CLK_PIN]  = p3_latch_q[P3_SER_CLK_PIN] & i_ser_txd;
    end
  end

  // synchronised pin levels routed to the serial engine and interrupt logic
  assign o_ser_sync_data_in   = (i_ser_mode == MPM_SER_SYNC) ? p3_sync[P3_SER_DATA_PIN]
                                                              : 1'b1;
  assign o_ser_rxd            = (i_ser_mode != MPM_SER_SYNC) ? p3_sync[P3_SER_DATA_PIN]
                                                              : 1'b1;
  assign o_external_irq_input = p3_sync[2];
  assign o_p3_pin_level       = p3_sync;

  // vertical event irq: real events always, dummy ones unless masked
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      vertical_event_irq_q <= 1'b0;
    end else begin
      vertical_event_irq_q <= i_vertical_event_irq_real |
                  (i_vertical_event_irq_dummy & ~clamp_ctrl_q.dummy_vertical_event_irq_mask);
    end
  end

  assign o_vertical_event_irq = vertical_event_irq_q;
  assign o_sync_ctrl          = sync_ctrl_q;
  assign o_clamp_ctrl         = clamp_ctrl_q;
  assign o_output_port_latch  = p4_latch_q;

  mpm_pin_cell #(.W(P1_W)) u_p1 (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_latch    (p1_latch_q),
    .i_alt_sel  (p1_alt_sel),
    .i_alt_val  (p1_alt_val),
    .i_pin_in   (i_p1_pin),
    .o_pin_out  (o_p1_pin),
    .o_pin_oe   (o_p1_pin_oe),
    .o_pin_sync (p1_sync)
  );

  mpm_pin_cell #(.W(P2_W)) u_p2 (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_latch    (p2_latch_q),
    .i_alt_sel  (p2_alt_sel),
    .i_alt_val  (p2_alt_val),
    .i_pin_in   (i_p2_pin),
    .o_pin_out  (o_p2_pin),
    .o_pin_oe   (o_p2_pin_oe),
    .o_pin_sync (p2_sync)
  );

  mpm_pin_cell #(.W(P3_W)) u_p3 (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_latch    (p3_drive),
    .i_alt_sel  ('0),
    .i_alt_val  ('1),
    .i_pin_in   (i_p3_pin),
    .o_pin_out  (o_p3_pin),
    .o_pin_oe   (o_p3_pin_oe),
    .o_pin_sync (p3_sync)
  );

endmodule : mpm_top

// ### sim/mpm_top_asserts.sv
module mpm_top_asserts (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_rst,
  input  wire logic [7:0]                      i_sfr_addr,
  input  wire logic                            i_sfr_wr,
  input  wire logic [7:0]                      i_sfr_wdata,
  input  wire mpm_pkg::mpm_sync_ctrl_t         o_sync_ctrl,
  input  wire mpm_pkg::mpm_clamp_ctrl_t        o_clamp_ctrl,
  input  wire logic                            i_hclamp_pulse,
  input  wire logic                            i_vsync_active,
  input  wire logic                            i_safe_area_out,
  input  wire logic [mpm_pkg::PWM_PIN_CNT-1:0] i_static_pwm,
  input  wire logic                            i_vertical_event_irq_real,
  input  wire logic                            i_vertical_event_irq_dummy,
  input  wire logic                            o_vertical_event_irq,
  input  wire logic [mpm_pkg::P1_W-1:0]        o_p1_pin,
  input  wire logic [mpm_pkg::P1_W-1:0]        o_p1_pin_oe,
  input  wire logic [mpm_pkg::P2_W-1:0]        o_p2_pin,
  input  wire logic [mpm_pkg::P2_W-1:0]        o_p2_pin_oe,
  input  wire logic [mpm_pkg::P4_W-1:0]        o_output_port_latch
);
  import mpm_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic [7:0] wd_q;
  logic       irq_exp_q;
  always_ff @(posedge i_core_clk) begin
    wd_q <= i_sfr_wdata;
  end
  // the dummy event only counts while its mask is clear
  always_ff @(posedge i_core_clk) begin
    irq_exp_q <= i_vertical_event_irq_real | (i_vertical_event_irq_dummy & ~o_clamp_ctrl.dummy_vertical_event_irq_mask);
  end
  a_sync_write: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_SYNC_PIN |=> o_sync_ctrl == {wd_q[7:4], wd_q[2:0]})
    else $error("sync control differs from written byte");
  a_clamp_write: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_CLAMP_PARA |=> o_clamp_ctrl == wd_q[6:5])
    else $error("clamp control differs from written byte");
  a_output_port_latch_write: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_OUT_PORT |=> o_output_port_latch == wd_q[6:0])
    else $error("output port latch differs from written byte");
  a_irq_follows: assert property (
    !$past(i_rst) |-> o_vertical_event_irq == irq_exp_q)
    else $error("vertical event irq wrong");
  a_reset_clear: assert property (
    $fell(i_rst) |-> o_sync_ctrl == '0 && o_clamp_ctrl == '0 && o_output_port_latch == '0
      && o_p1_pin_oe == '0 && o_p2_pin_oe == '0)
    else $error("state not cleared by reset");
  a_clamp_pin: assert property (
    o_p1_pin_oe[P1_CLAMP_PIN] && o_p1_pin[P1_CLAMP_PIN] |-> $past(i_hclamp_pulse)
      && !($past(i_vsync_active) && $past(o_sync_ctrl.clamp_suppress_in_vsync)))
    else $error("clamp pin high without clamp pulse");
  a_safe_pin: assert property (
    o_p1_pin_oe[P1_SAFE_PIN] && o_p1_pin[P1_SAFE_PIN] |-> $past(i_safe_area_out))
    else $error("safe area pin high without source");
  a_pwm_pin: assert property (
    o_p2_pin_oe[P2_PWM_BASE] && o_p2_pin[P2_PWM_BASE] |-> $past(i_static_pwm[0]))
    else $error("pwm pin high without source");
  c_irq_dummy: cover property (i_vertical_event_irq_dummy ##1 o_vertical_event_irq);
  c_clamp_alt: cover property (o_p1_pin_oe[P1_CLAMP_PIN] && o_p1_pin[P1_CLAMP_PIN]);
  c_pwm_alt: cover property (o_p2_pin_oe[P2_PWM_BASE] && o_p2_pin[P2_PWM_BASE]);
endmodule : mpm_top_asserts

bind mpm_top mpm_top_asserts u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .o_sync_ctrl(o_sync_ctrl), .o_clamp_ctrl(o_clamp_ctrl),
  .i_hclamp_pulse(i_hclamp_pulse), .i_vsync_active(i_vsync_active),
  .i_safe_area_out(i_safe_area_out), .i_static_pwm(i_static_pwm),
  .i_vertical_event_irq_real(i_vertical_event_irq_real), .i_vertical_event_irq_dummy(i_vertical_event_irq_dummy),
  .o_vertical_event_irq(o_vertical_event_irq), .o_p1_pin(o_p1_pin),
  .o_p1_pin_oe(o_p1_pin_oe), .o_p2_pin(o_p2_pin), .o_p2_pin_oe(o_p2_pin_oe),
  .o_output_port_latch(o_output_port_latch));

// ### sim/mpm_pin_env.sv
module mpm_pin_env #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_ext_low,
  output logic      [W-1:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins sit on the pull-up unless the board pulls them low
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_level[k] = i_oe[k] ? i_out[k] : !i_ext_low[k];
    end
  end
endmodule : mpm_pin_env

// ### sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mpm_pkg::*;
  localparam logic [7:0] A_P1 = 8'h90;
  localparam logic [7:0] A_P2 = 8'hA0;
  localparam logic [7:0] A_P3 = 8'hB0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, x2 = 8'h00, x3 = 8'h00, l2, l3;
  logic [7:0] p2o, p2e, p3o, p3e, p3l;
  logic wr_s = 1'b0, rd_s = 1'b0, hcl = 1'b0, vsa = 1'b0, safe_area_out = 1'b0, self_test_pattern_out = 1'b0;
  logic vr = 1'b0, vd = 1'b0, sd = 1'b1, sc = 1'b1, tx = 1'b1, irq, rxd, sdin, eirq;
  logic [3:0] pwm = 4'h0;
  logic [5:0] x1 = 6'h00, l1, p1o, p1e;
  logic [6:0] p4;
  mpm_ser_mode_t mode = MPM_SER_SYNC;
  mpm_sync_ctrl_t sync_c;
  mpm_clamp_ctrl_t clamp_c;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  mpm_top #(.ADDR_P1(A_P1), .ADDR_P2(A_P2), .ADDR_P3(A_P3)) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr_s), .i_sfr_rd(rd_s),
    .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .o_sync_ctrl(sync_c), .o_clamp_ctrl(clamp_c),
    .i_hclamp_pulse(hcl), .i_vsync_active(vsa), .i_safe_area_out(safe_area_out),
    .i_self_test_pattern(self_test_pattern_out), .i_static_pwm(pwm), .i_vertical_event_irq_real(vr),
    .i_vertical_event_irq_dummy(vd), .o_vertical_event_irq(irq), .i_ser_mode(mode),
    .i_ser_sync_data_out(sd), .i_ser_sync_clk_out(sc), .i_ser_txd(tx),
    .o_ser_sync_data_in(sdin), .o_ser_rxd(rxd), .o_external_irq_input(eirq),
    .i_p1_pin(l1), .o_p1_pin(p1o), .o_p1_pin_oe(p1e), .i_p2_pin(l2), .o_p2_pin(p2o),
    .o_p2_pin_oe(p2e), .i_p3_pin(l3), .o_p3_pin(p3o), .o_p3_pin_oe(p3e),
    .o_p3_pin_level(p3l), .o_output_port_latch(p4));
  mpm_pin_env #(.W(P1_W)) ENV1 (.i_out(p1o), .i_oe(p1e), .i_ext_low(x1), .o_level(l1));
  mpm_pin_env #(.W(P2_W)) ENV2 (.i_out(p2o), .i_oe(p2e), .i_ext_low(x2), .o_level(l2));
  mpm_pin_env #(.W(P3_W)) ENV3 (.i_out(p3o), .i_oe(p3e), .i_ext_low(x3), .o_level(l3));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // strobe drops for a full cycle so back-to-back calls never retoggle it in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_s = 1'b1;
    addr = a;
    wd = d;
    cyc(1);
    wr_s = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_s = 1'b1;
    addr = a;
    cyc(1);
    rd_s = 1'b0;
    d = rdata;
    cyc(1);
  endtask : rd
  task automatic t_reset();
    logic [7:0] d;
    chk("sync", 8'h00, {1'b0, sync_c});
    chk("clamp", 8'h00, {6'h00, clamp_c});
    chk("p1 level", 8'h3F, {2'b00, l1});
    rd(ADDR_SPECIAL, d);
    chk("special", 8'h00, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_SYNC_PIN, 8'h01 << i);
      d = (i < 3) ? 8'h01 << i : (i == 3) ? 8'h00 : 8'h01 << (i - 1);
      chk("sync bit", d, {1'b0, sync_c});
    end
    rd(ADDR_SYNC_PIN, d);
    chk("sync read", 8'h00, d);
    wr(ADDR_CLAMP_PARA, 8'hFF);
    chk("clamp", 8'h03, {6'h00, clamp_c});
    rd(ADDR_CLAMP_PARA, d);
    chk("clamp read", 8'h60, d);
    wr(ADDR_CLAMP_PARA, 8'h00);
    wr(ADDR_SYNC_PIN, 8'h00);
    $display("test control done");
  endtask : t_ctrl
  task automatic t_irq();
    vd = 1'b1;
    cyc(1);
    chk("irq dummy", 8'h01, {7'h00, irq});
    vd = 1'b0;
    wr(ADDR_CLAMP_PARA, 8'h40);
    vd = 1'b1;
    cyc(1);
    chk("irq masked", 8'h00, {7'h00, irq});
    vd = 1'b0;
    vr = 1'b1;
    cyc(1);
    chk("irq real", 8'h01, {7'h00, irq});
    vr = 1'b0;
    wr(ADDR_CLAMP_PARA, 8'h00);
    $display("test irq done");
  endtask : t_irq
  task automatic t_port();
    logic [7:0] d;
    wr(A_P1, 8'h00);
    chk("p1 low", 8'h00, {2'b00, l1});
    wr(A_P2, 8'h5A);
    chk("p2 level", 8'h5A, l2);
    wr(A_P1, 8'h3F);
    x1 = 6'h15;
    cyc(3);
    rd(A_P1, d);
    chk("p1 read", 8'h2A, d & 8'h3F);
    x1 = 6'h00;
    $display("test port done");
  endtask : t_port
  task automatic t_alt();
    logic [7:0] d;
    hcl = 1'b1;
    safe_area_out = 1'b1;
    wr(ADDR_SPECIAL, 8'h30);
    wr(A_P1, 8'h0F);
    chk("p1 alt", 8'h3F, {2'b00, l1});
    vsa = 1'b1;
    wr(ADDR_SYNC_PIN, 8'h80);
    chk("p1 suppressed", 8'h2F, {2'b00, l1});
    wr(ADDR_SYNC_PIN, 8'h00);
    vsa = 1'b0;
    wr(ADDR_SPECIAL, 8'h00);
    chk("p1 alt off", 8'h0F, {2'b00, l1});
    hcl = 1'b0;
    safe_area_out = 1'b0;
    wr(ADDR_SPECIAL, 8'h30);
    wr(A_P1, 8'h3F);
    chk("p1 latch high", 8'h3F, {2'b00, l1});
    pwm = 4'b1011;
    self_test_pattern_out = 1'b1;
    wr(A_P2, 8'h00);
    wr(ADDR_SPECIAL, 8'hCF);
    chk("p2 alt inv", 8'hB0, l2);
    wr(ADDR_SPECIAL, 8'h4F);
    chk("p2 alt", 8'hB8, l2);
    rd(ADDR_SPECIAL, d);
    chk("special read", 8'h4F, d);
    $display("test alternate done");
  endtask : t_alt
  task automatic t_ser();
    wr(A_P3, 8'hFF);
    mode = MPM_SER_UART8;
    tx = 1'b0;
    cyc(2);
    chk("txd low", 8'h00, {7'h00, l3[1]});
    tx = 1'b1;
    x3 = 8'h01;
    cyc(3);
    chk("rxd txd", 8'h02, {6'h00, l3[1], rxd});
    x3 = 8'h00;
    mode = MPM_SER_SYNC;
    sd = 1'b0;
    sc = 1'b0;
    cyc(2);
    chk("mode0 low", 8'h00, {6'h00, l3[1:0]});
    sd = 1'b1;
    sc = 1'b1;
    cyc(2);
    chk("mode0 high", 8'h03, {6'h00, l3[1:0]});
    x3 = 8'h05;
    cyc(3);
    chk("mode0 inputs", 8'h01, {5'h00, eirq, sdin, rxd});
    chk("p3 level", 8'hFA, p3l);
    x3 = 8'h00;
    $display("test serial done");
  endtask : t_ser
  task automatic t_p4();
    logic [7:0] d;
    wr(ADDR_OUT_PORT, 8'hFF);
    chk("p4", 8'h7F, {1'b0, p4});
    rd(ADDR_OUT_PORT, d);
    chk("p4 read", 8'h00, d);
    $display("test output_port_latch done");
  endtask : t_p4
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_ctrl();
    t_irq();
    t_port();
    t_alt();
    t_ser();
    t_p4();
    test_done();
  end
endmodule : tb_top
